/* pcpc_pkg.sv */
// Shared constants and types for the pixel clock and power control block
package pcpc_pkg;
  // Register addresses on the serial port
  localparam logic [7:0] PCPC_DIV_HI_ADDR = 8'h01;
  localparam logic [7:0] PCPC_DIV_LO_ADDR = 8'h02;
  localparam logic [7:0] PCPC_LOOP_ADDR = 8'h03;
  localparam logic [7:0] PCPC_PHASE_ADDR = 8'h04;
  localparam logic [7:0] PCPC_POL_ADDR = 8'h0e;
  localparam logic [7:0] PCPC_PWR_ADDR = 8'h0f;
  localparam logic [7:0] PCPC_SYNC_ADDR = 8'h14;
  // Reset values
  localparam logic [7:0] PCPC_DIV_HI_RST = 8'h69;
  localparam logic [7:0] PCPC_DIV_LO_RST = 8'hd0;
  localparam logic [7:0] PCPC_LOOP_RST = 8'h48;
  localparam logic [7:0] PCPC_PHASE_RST = 8'h80;
  localparam logic [7:0] PCPC_POL_RST = 8'h48;
  localparam logic [7:0] PCPC_PWR_RST = 8'h02;
  // Field positions
  localparam int PCPC_DIV_LO_HI = 7;
  localparam int PCPC_DIV_LO_LO = 4;
  localparam int PCPC_RANGE_HI = 7;
  localparam int PCPC_RANGE_LO = 6;
  localparam int PCPC_PUMP_HI = 5;
  localparam int PCPC_PUMP_LO = 3;
  localparam int PCPC_PHASE_HI = 7;
  localparam int PCPC_PHASE_LO = 3;
  localparam int PCPC_POL_LINE_BIT = 6;
  localparam int PCPC_POL_FRZ_BIT = 3;
  localparam int PCPC_PWR_BIT = 1;
  localparam int PCPC_DET_LINE_BIT = 7;
  localparam int PCPC_DET_GREEN_BIT = 4;
  localparam int PCPC_DET_AUX_BIT = 1;
  // Loop and timing figures
  localparam int PCPC_DIV_MIN = 221;
  localparam int PCPC_DIV_MAX = 4095;
  localparam int PCPC_PHASE_SHIFT = 5;
  localparam int PCPC_PIPE_DEPTH = 4;
  localparam int PCPC_CLK_PERIOD_NS = 10;
  localparam int PCPC_ACT_WINDOW_NS = 100000;
  localparam int PCPC_ACT_CYCLES =
    PCPC_ACT_WINDOW_NS / PCPC_CLK_PERIOD_NS;
  localparam logic [15:0] PCPC_PERIOD_MIN = 16'h0002;
  localparam logic [15:0] PCPC_PERIOD_MAX = 16'hffff;
  localparam logic [15:0] PCPC_PERIOD_RST = 16'h0004;
  // One-hot oscillator band selects and the range codes that pick them
  localparam logic [2:0] PCPC_BAND_LOW = 3'h1;
  localparam logic [2:0] PCPC_BAND_MID = 3'h2;
  localparam logic [2:0] PCPC_BAND_HIGH = 3'h4;
  localparam logic [1:0] PCPC_RANGE_LOW = 2'h0;
  localparam logic [1:0] PCPC_RANGE_MID = 2'h1;

  typedef enum logic [1:0] {PWR_FULL, PWR_SEEK, PWR_DOWN} pcpc_pwr_t;

  // Pump current in microamps for each code
  function automatic logic [10:0] pcpc_pump_ua(input logic [2:0] code);
    unique case (code)
      3'h0: pcpc_pump_ua = 11'h032;
      3'h1: pcpc_pump_ua = 11'h064;
      3'h2: pcpc_pump_ua = 11'h096;
      3'h3: pcpc_pump_ua = 11'h0fa;
      3'h4: pcpc_pump_ua = 11'h15e;
      3'h5: pcpc_pump_ua = 11'h1f4;
      3'h6: pcpc_pump_ua = 11'h2ee;
      3'h7: pcpc_pump_ua = 11'h5dc;
    endcase
  endfunction
endpackage

/* pcpc_reg_if.sv */
// Register access path between serial port and control core
`timescale 1ns/10ps
`default_nettype none
interface pcpc_reg_if;
  logic wr_en;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  modport port(output wr_en, output addr, output wdata, input rdata);
  modport core(input wr_en, input addr, input wdata, output rdata);
endinterface
`default_nettype wire

/* pcpc_serial_port.sv */
// Two-wire serial register port slave with address auto-increment
`timescale 1ns/10ps
`default_nettype none
module pcpc_serial_port
  import pcpc_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR = 7'h4c // Arbitrary value
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic scl_pin,
  input wire logic sda_in,
  output logic sda_oe_n,
  pcpc_reg_if.port bus
);
  typedef enum logic [2:0] {
    S_IDLE, S_DEV, S_SUB, S_WR, S_ACK, S_RD, S_RACK, S_RNEXT
  } pcpc_sp_t;
  pcpc_sp_t st_reg, after_reg;
  logic [1:0] scl_sy_reg, sda_sy_reg;
  logic scl_d_reg, sda_d_reg, acked_reg, wr_reg;
  logic [7:0] sh_reg, ptr_reg, wd_reg;
  logic [2:0] cnt_reg;
  wire scl_s = scl_sy_reg[1];
  wire sda_s = sda_sy_reg[1];
  wire scl_rise = scl_s & ~scl_d_reg;
  wire scl_fall = ~scl_s & scl_d_reg;
  wire start_det = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
  wire stop_det = scl_s & scl_d_reg & ~sda_d_reg & sda_s;
  wire [7:0] byte_w = {sh_reg[6:0], sda_s};
  wire last_bit = (cnt_reg == 3'h7);

  assign bus.wr_en = wr_reg;
  assign bus.addr = ptr_reg;
  assign bus.wdata = wd_reg;

  // Pins pass two flops; edges look only at the second stage
  always_ff @(posedge sys_clk) begin
    scl_sy_reg <= {scl_sy_reg[0], scl_pin};
    sda_sy_reg <= {sda_sy_reg[0], sda_in};
    scl_d_reg <= scl_s;
    sda_d_reg <= sda_s;
  end

  // Byte engine; the write strobe lasts one cycle
  always_ff @(posedge sys_clk) begin
    wr_reg <= 1'b0;
    if (!rst_n) begin
      st_reg <= S_IDLE;
      after_reg <= S_IDLE;
      sda_oe_n <= 1'b1;
      cnt_reg <= 3'h0;
      sh_reg <= 8'h00;
      ptr_reg <= 8'h00;
      wd_reg <= 8'h00;
      acked_reg <= 1'b0;
    end else if (start_det) begin
      st_reg <= S_DEV;
      cnt_reg <= 3'h0;
      sda_oe_n <= 1'b1;
    end else if (stop_det) begin
      st_reg <= S_IDLE;
      sda_oe_n <= 1'b1;
    end else begin
      unique case (st_reg)
        S_IDLE: ;
        S_DEV, S_SUB, S_WR: if (scl_rise) begin
          sh_reg <= byte_w;
          cnt_reg <= cnt_reg + 3'h1;
          if (last_bit) begin
            st_reg <= S_ACK;
            acked_reg <= 1'b0;
            if (st_reg == S_DEV) begin
              after_reg <= byte_w[0] ? S_RD : S_SUB;
              if (byte_w[7:1] != DEV_ADDR) st_reg <= S_IDLE;
            end else if (st_reg == S_SUB) begin
              ptr_reg <= byte_w;
              after_reg <= S_WR;
            end else begin
              wd_reg <= byte_w;
              wr_reg <= 1'b1;
              after_reg <= S_WR;
            end
          end
        end
        S_ACK: if (scl_fall) begin
          acked_reg <= 1'b1;
          sda_oe_n <= acked_reg;
          if (acked_reg) begin
            st_reg <= after_reg;
            cnt_reg <= 3'h0;
            if (after_reg == S_RD) begin
              sh_reg <= bus.rdata;
              sda_oe_n <= bus.rdata[7];
            end
          end
        end
        S_RD: if (scl_fall) begin
          cnt_reg <= cnt_reg + 3'h1;
          sda_oe_n <= last_bit ? 1'b1 : sh_reg[6];
          sh_reg <= {sh_reg[6:0], 1'b1};
          if (last_bit) st_reg <= S_RACK;
        end
        S_RACK: if (scl_rise) begin
          st_reg <= sda_s ? S_IDLE : S_RNEXT;
          if (!sda_s) ptr_reg <= ptr_reg + 8'h01;
        end
        S_RNEXT: if (scl_fall) begin
          sh_reg <= bus.rdata;
          sda_oe_n <= bus.rdata[7];
          cnt_reg <= 3'h0;
          st_reg <= S_RD;
        end
      endcase
      if (wr_reg) ptr_reg <= ptr_reg + 8'h01;
    end
  end
endmodule
`default_nettype wire

/* pcpc_phase_delay.sv */
// Delays pixel tick and line sync by phase/32 of a pixel period
`timescale 1ns/10ps
`default_nettype none
module pcpc_phase_delay
  import pcpc_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic tick_in,
  input wire logic sync_in,
  input wire logic [15:0] period,
  input wire logic [4:0] phase,
  output logic tick_out,
  output logic sync_out
);
  logic [15:0] cnt_reg;
  logic pend_reg, sync_reg;
  wire [20:0] prod = period * phase;
  wire [15:0] delay = prod[20:PCPC_PHASE_SHIFT];

  // Same delay for both keeps sync aligned with the shifted clock
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      cnt_reg <= 16'h0000;
      pend_reg <= 1'b0;
      sync_reg <= 1'b0;
      tick_out <= 1'b0;
      sync_out <= 1'b0;
    end else begin
      tick_out <= 1'b0;
      // At the largest phase with a period of 32 or less a new tick lands on the expiry cycle; both act
      if (pend_reg && cnt_reg == 16'h0000) begin
        pend_reg <= 1'b0;
        tick_out <= 1'b1;
        sync_out <= sync_reg;
      end else if (pend_reg) begin
        cnt_reg <= cnt_reg - 16'h0001;
      end
      if (tick_in) begin
        cnt_reg <= delay;
        pend_reg <= 1'b1;
        sync_reg <= sync_in;
      end
    end
  end
endmodule
`default_nettype wire

/* pcpc_top.sv */
// Pixel clock loop control, phase adjust and power state selection
// How it works
// - Feedback divide ratio is the programmed divider value plus one.
// - Divider comes from registers 01 and 02, dividing the pixel clock.
// - Divided clock is phase compared with line sync to steer the loop.
// - Range code 00 low band, 01 middle band, other codes high band.
// - Pump code 0 to 7 selects 50 up to 1500 microamps.
// - Sampling phase moves in 32 equal steps from a 5-bit field.
// - Line sync output gets the same phase shift as the clock.
// - While freeze is active the loop ignores line sync, holds frequency.
// - Line sync and freeze inputs each have polarity bits, 1 is high.
// - Exactly three power states: full, seek, powered down.
// - Power bit 0 forces down; else sync present full, absent seek.
// - Seek and down keep only port, detectors, slicer, reference on.
// - Power control bit sits at bit 1 of register 0f.
// - Sync detected is the OR of bits 7, 4 and 1 of register 14.
// - Data clock rises midway between output data transitions.
// - First four pipeline outputs after start-up are not valid.
// - Divider bits 11:4 in register 01, bits 3:0 in 02 bits 7:4.
// - Range field in 03 bits 7:6, pump field in 03 bits 5:3.
// - Larger phase values give more delay, one step per period/32.
// - Freeze is asynchronous and disables the loop reference input.
`timescale 1ns/10ps
`default_nettype none
module pcpc_top
  import pcpc_pkg::*;
#(
  parameter int ACT_CYCLES = PCPC_ACT_CYCLES,
  parameter logic [6:0] DEV_ADDR = 7'h4c // Arbitrary value
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic line_sync_pin,
  input wire logic freeze_pin,
  input wire logic green_sync_pin,
  input wire logic aux_sync_pin,
  input wire logic scl_pin,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n,
  output logic pixel_tick,
  output logic data_clk_out,
  output logic aligned_line_sync_out,
  output logic data_valid,
  output logic [2:0] band_sel,
  output logic [10:0] pump_ua,
  output logic core_power_en,
  output logic keepalive_en,
  output logic [1:0] power_state
);
  pcpc_reg_if regs ();

  // Register storage
  logic [7:0] div_hi_reg, div_lo_reg, loop_reg, phase_reg;
  logic [7:0] pol_reg, pwr_reg;
  logic sda_oe_n_w;

  pcpc_serial_port #(.DEV_ADDR(DEV_ADDR)) u_port (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .scl_pin(scl_pin),
    .sda_in(sda_in),
    .sda_oe_n(sda_oe_n_w),
    .bus(regs.port)
  );

  // Register writes; the status register takes no writes
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      div_hi_reg <= PCPC_DIV_HI_RST;
      div_lo_reg <= PCPC_DIV_LO_RST;
      loop_reg <= PCPC_LOOP_RST;
      phase_reg <= PCPC_PHASE_RST;
      pol_reg <= PCPC_POL_RST;
      pwr_reg <= PCPC_PWR_RST;
    end else if (regs.wr_en) begin
      if (regs.addr == PCPC_DIV_HI_ADDR) div_hi_reg <= regs.wdata;
      if (regs.addr == PCPC_DIV_LO_ADDR) div_lo_reg <= regs.wdata;
      if (regs.addr == PCPC_LOOP_ADDR) loop_reg <= regs.wdata;
      if (regs.addr == PCPC_PHASE_ADDR) phase_reg <= regs.wdata;
      if (regs.addr == PCPC_POL_ADDR) pol_reg <= regs.wdata;
      if (regs.addr == PCPC_PWR_ADDR) pwr_reg <= regs.wdata;
    end
  end

  // Field extraction
  wire [11:0] div_val =
    {div_hi_reg, div_lo_reg[PCPC_DIV_LO_HI:PCPC_DIV_LO_LO]};
  wire [12:0] div_ratio = {1'b0, div_val} + 13'h0001;
  wire [1:0] osc_range_field =
    loop_reg[PCPC_RANGE_HI:PCPC_RANGE_LO];
  wire osc_range_hi_bit = osc_range_field[1];
  wire osc_range_lo_bit = osc_range_field[0];
  wire [2:0] pump_field = loop_reg[PCPC_PUMP_HI:PCPC_PUMP_LO];
  wire pump_sel_bit2 = pump_field[2];
  wire pump_sel_bit1 = pump_field[1];
  wire pump_sel_bit0 = pump_field[0];
  wire [4:0] phase_field = phase_reg[PCPC_PHASE_HI:PCPC_PHASE_LO];
  wire line_pol = pol_reg[PCPC_POL_LINE_BIT];
  wire frz_pol = pol_reg[PCPC_POL_FRZ_BIT];
  wire pwr_on_bit = pwr_reg[PCPC_PWR_BIT];

  // Input synchronisers; polarity is applied after the second flop so
  // no logic sits in front of the first one
  logic [1:0] line_sy_reg, frz_sy_reg, green_sy_reg, aux_sy_reg;
  always_ff @(posedge sys_clk) begin
    line_sy_reg <= {line_sy_reg[0], line_sync_pin};
    frz_sy_reg <= {frz_sy_reg[0], freeze_pin};
    green_sy_reg <= {green_sy_reg[0], green_sync_pin};
    aux_sy_reg <= {aux_sy_reg[0], aux_sync_pin};
  end
  wire line_s = line_sy_reg[1] ~^ line_pol;
  wire freeze_s = frz_sy_reg[1] ~^ frz_pol;

  // Activity detectors: an edge within the window marks a source live
  wire [2:0] act_in = {line_s, green_sy_reg[1], aux_sy_reg[1]};
  logic [2:0] act_live;
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_act
      logic prev_reg, live_reg;
      logic [15:0] tmo_reg;
      wire edge_w = act_in[gi] ^ prev_reg;
      always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
          prev_reg <= 1'b0;
          live_reg <= 1'b0;
          tmo_reg <= 16'h0000;
        end else begin
          prev_reg <= act_in[gi];
          if (edge_w) begin
            live_reg <= 1'b1;
            tmo_reg <= 16'(ACT_CYCLES);
          end else if (tmo_reg != 16'h0000) begin
            tmo_reg <= tmo_reg - 16'h0001;
          end else begin
            live_reg <= 1'b0;
          end
        end
      end
      assign act_live[gi] = live_reg;
    end
  endgenerate

  // Status register layout and the combined detect flag
  wire [7:0] sync_status = (8'(act_live[2]) << PCPC_DET_LINE_BIT) |
    (8'(act_live[1]) << PCPC_DET_GREEN_BIT) |
    (8'(act_live[0]) << PCPC_DET_AUX_BIT);
  wire sync_det = sync_status[PCPC_DET_LINE_BIT] |
    sync_status[PCPC_DET_GREEN_BIT] |
    sync_status[PCPC_DET_AUX_BIT];

  // Read mux; unmapped addresses read as zero
  assign regs.rdata =
    (regs.addr == PCPC_DIV_HI_ADDR) ? div_hi_reg :
    (regs.addr == PCPC_DIV_LO_ADDR) ? div_lo_reg :
    (regs.addr == PCPC_LOOP_ADDR) ? loop_reg :
    (regs.addr == PCPC_PHASE_ADDR) ? phase_reg :
    (regs.addr == PCPC_POL_ADDR) ? pol_reg :
    (regs.addr == PCPC_PWR_ADDR) ? pwr_reg :
    (regs.addr == PCPC_SYNC_ADDR) ? sync_status : 8'h00;

  // Power state choice: software off beats automatic selection
  pcpc_pwr_t pwr_state_reg, pwr_next;
  assign pwr_next = !pwr_on_bit ? PWR_DOWN :
    (sync_det ? PWR_FULL : PWR_SEEK);
  wire full_pwr = (pwr_state_reg == PWR_FULL);

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      pwr_state_reg <= PWR_SEEK;
      core_power_en <= 1'b0;
      keepalive_en <= 1'b1;
      power_state <= PWR_SEEK;
    end else begin
      pwr_state_reg <= pwr_next;
      core_power_en <= (pwr_next == PWR_FULL);
      keepalive_en <= 1'b1;
      power_state <= pwr_next;
    end
  end

  // Loop reference: line sync rising edge, gated off by freeze
  logic line_d_reg;
  always_ff @(posedge sys_clk) begin
    if (!rst_n) line_d_reg <= 1'b0;
    else line_d_reg <= line_s;
  end
  wire ref_edge = line_s & ~line_d_reg & ~freeze_s & full_pwr;

  // Digital oscillator: one pixel tick every period_reg cycles
  logic [15:0] period_reg, dco_cnt_reg;
  logic dco_tick_reg;
  always_ff @(posedge sys_clk) begin
    if (!rst_n || !full_pwr) begin
      dco_cnt_reg <= 16'h0000;
      dco_tick_reg <= 1'b0;
    end else if (dco_cnt_reg + 16'h0001 >= period_reg) begin
      dco_cnt_reg <= 16'h0000;
      dco_tick_reg <= 1'b1;
    end else begin
      dco_cnt_reg <= dco_cnt_reg + 16'h0001;
      dco_tick_reg <= 1'b0;
    end
  end

  // Feedback divider: one edge per div_ratio pixel ticks
  logic [12:0] fb_cnt_reg;
  logic fb_edge_reg;
  wire fb_wrap = (fb_cnt_reg + 13'h0001 >= div_ratio);
  always_ff @(posedge sys_clk) begin
    if (!rst_n || !full_pwr) begin
      fb_cnt_reg <= 13'h0000;
      fb_edge_reg <= 1'b0;
    end else begin
      fb_edge_reg <= dco_tick_reg & fb_wrap;
      if (dco_tick_reg) fb_cnt_reg <= fb_wrap ? 13'h0000 :
        fb_cnt_reg + 13'h0001;
    end
  end

  // Bang-bang phase detector: whichever edge comes first sets a
  // pending flag, the other one decides the step direction
  logic ref_pend_reg, fb_pend_reg;
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      ref_pend_reg <= 1'b0;
      fb_pend_reg <= 1'b0;
      period_reg <= PCPC_PERIOD_RST;
    end else if (freeze_s) begin
      // Frequency held; stale edges dropped
      ref_pend_reg <= 1'b0;
      fb_pend_reg <= 1'b0;
    end else if (ref_edge && fb_edge_reg) begin
      ref_pend_reg <= 1'b0;
      fb_pend_reg <= 1'b0;
    end else if (ref_edge) begin
      if (fb_pend_reg) begin
        fb_pend_reg <= 1'b0;
        if (period_reg != PCPC_PERIOD_MAX)
          period_reg <= period_reg + 16'h0001;
      end else begin
        ref_pend_reg <= 1'b1;
      end
    end else if (fb_edge_reg) begin
      if (ref_pend_reg) begin
        ref_pend_reg <= 1'b0;
        if (period_reg != PCPC_PERIOD_MIN)
          period_reg <= period_reg - 16'h0001;
      end else begin
        fb_pend_reg <= 1'b1;
      end
    end
  end

  // Phase shift of clock and sync share one delay line
  logic sh_tick, sh_sync;
  pcpc_phase_delay u_phase (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .tick_in(dco_tick_reg),
    .sync_in(line_s),
    .period(period_reg),
    .phase(phase_field),
    .tick_out(sh_tick),
    .sync_out(sh_sync)
  );

  // Data changes on the shifted tick; clock rises half a period later
  logic [15:0] half_cnt_reg;
  wire [15:0] half_period = {1'b0, period_reg[15:1]};
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      half_cnt_reg <= 16'h0000;
      data_clk_out <= 1'b0;
    end else if (sh_tick) begin
      half_cnt_reg <= half_period;
      data_clk_out <= 1'b0;
    end else if (half_cnt_reg > 16'h0001) begin
      half_cnt_reg <= half_cnt_reg - 16'h0001;
    end else if (half_cnt_reg == 16'h0001) begin
      half_cnt_reg <= 16'h0000;
      data_clk_out <= 1'b1;
    end
  end

  // Pipeline fill: four outputs pass before data counts as valid
  logic [2:0] fill_reg;
  always_ff @(posedge sys_clk) begin
    if (!rst_n || !full_pwr) begin
      fill_reg <= 3'h0;
      data_valid <= 1'b0;
    end else if (sh_tick) begin
      if (fill_reg != 3'(PCPC_PIPE_DEPTH))
        fill_reg <= fill_reg + 3'h1;
      data_valid <= (fill_reg == 3'(PCPC_PIPE_DEPTH));
    end
  end

  // Output registers for ticks, band and pump decode
  wire [1:0] range_code = {osc_range_hi_bit, osc_range_lo_bit};
  wire [2:0] band_w = (range_code == PCPC_RANGE_LOW) ?
    PCPC_BAND_LOW : (range_code == PCPC_RANGE_MID) ?
    PCPC_BAND_MID : PCPC_BAND_HIGH;
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      pixel_tick <= 1'b0;
      aligned_line_sync_out <= 1'b0;
      band_sel <= PCPC_BAND_LOW;
      pump_ua <= 11'h000;
      sda_out <= 1'b0;
      sda_oe_n <= 1'b1;
    end else begin
      pixel_tick <= sh_tick;
      aligned_line_sync_out <= sh_sync;
      band_sel <= band_w;
      pump_ua <= pcpc_pump_ua(
        {pump_sel_bit2, pump_sel_bit1, pump_sel_bit0});
      sda_out <= 1'b0;
      sda_oe_n <= sda_oe_n_w;
    end
  end

  // Checks on the loop, decode and power logic
  power_down_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !pwr_on_bit |=> power_state == 2'(PWR_DOWN))
    else $error("power bit low did not force power down");
  power_auto_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    pwr_on_bit && sync_det |=> core_power_en)
    else $error("sync present but core not powered");
  keep_alive_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $past(rst_n) |-> keepalive_en)
    else $error("keep-alive domain switched off");
  band_dec_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    osc_range_field == 2'h1 |=> band_sel == 3'h2)
    else $error("middle range code decoded wrongly");
  pump_dec_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    pump_field == 3'h7 |=> pump_ua == 11'h5dc)
    else $error("top pump code decoded wrongly");
  freeze_hold_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    freeze_s && $past(freeze_s) |-> $stable(period_reg))
    else $error("frequency moved during freeze");
  fb_ratio_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    fb_edge_reg |-> fb_cnt_reg == 13'h0000)
    else $error("feedback edge without divider wrap");
  valid_fill_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    data_valid |-> fill_reg == 3'h4)
    else $error("data valid before pipeline filled");
  clk_mid_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    sh_tick |=> !data_clk_out)
    else $error("data clock high at data change");
endmodule
`default_nettype wire

/* pcpc_src_model.sv */
// Graphics source model: sync pulses on three lines and a freeze level
`timescale 1ns/10ps
`default_nettype none
module pcpc_src_model (
  input wire logic sys_clk,
  input wire logic [2:0] en,
  input wire logic frz_req,
  output logic [2:0] sync,
  output logic freeze
);
  int cnt = 0;
  // Line period of 40 cycles, disturbed to 14 while frozen to upset a loop
  always @(negedge sys_clk) begin
    cnt <= (cnt >= (frz_req ? 13 : 39)) ? 0 : cnt + 1;
  end
  // Pulses are active high to match the reset polarity setting
  assign sync = (cnt < 4) ? en : 3'h0;
  assign freeze = frz_req;
endmodule
`default_nettype wire

/* tb_top.sv */
// Self-checking bench for the pixel clock and power control block
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin mismatches++; \
  $display("MISMATCH %0t got %h exp %h", $time, a, e); end end
module tb_top;
  import pcpc_pkg::*;
  logic sys_clk = 0, rst_n = 0, m_scl = 1, m_sda = 1, frz_on = 0;
  logic [2:0] src_en = 0;
  logic [2:0] sy;
  logic frz, sda_out, sda_oe_n, pixel_tick, data_valid, core_power_en;
  logic keepalive_en, data_clk_out, ls_out, dck_hi;
  logic [2:0] band_sel;
  logic [10:0] pump_ua;
  logic [1:0] power_state;
  logic [7:0] rd;
  int checks = 0, mismatches = 0, seed = 24063, div, t0, t1;
  int pump_tab[8] = '{50, 100, 150, 250, 350, 500, 750, 1500};
  // Pulled-up wire: low when master or slave pulls it
  wire sda_w = m_sda & (sda_oe_n | sda_out);
  pcpc_top #(.ACT_CYCLES(50)) u_dut (.sys_clk(sys_clk), .rst_n(rst_n),
    .line_sync_pin(sy[0]), .freeze_pin(frz), .green_sync_pin(sy[1]),
    .aux_sync_pin(sy[2]), .scl_pin(m_scl), .sda_in(sda_w),
    .sda_out(sda_out), .sda_oe_n(sda_oe_n), .pixel_tick(pixel_tick),
    .data_clk_out(data_clk_out), .aligned_line_sync_out(ls_out),
    .data_valid(data_valid),
    .band_sel(band_sel), .pump_ua(pump_ua), .core_power_en(core_power_en),
    .keepalive_en(keepalive_en), .power_state(power_state));
  pcpc_src_model u_src (.sys_clk(sys_clk), .en(src_en), .frz_req(frz_on),
    .sync(sy), .freeze(frz));
  initial forever #5 sys_clk = ~sys_clk;
  // Expected power state: power bit low wins, else any activity bit
  function automatic int pwr(input int pd, input int st);
    return (pd == 0) ? 2 : ((st & 8'h92) != 0) ? 0 : 1;
  endfunction
  // Half bit: clock moves first, data a cycle later, so no false start
  task automatic hb(input logic c, input logic d);
    m_scl = c;
    @(negedge sys_clk);
    m_sda = d;
    repeat (5) @(negedge sys_clk);
  endtask
  task automatic put(input logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      hb(0, b[i]);
      hb(1, b[i]);
    end
    hb(0, 1);
    hb(1, 1);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    hb(1, 1);
    hb(1, 0);
    put(8'h98);
    put(a);
    put(d);
    hb(0, 0);
    hb(1, 0);
    hb(1, 1);
  endtask
  task automatic rr(input logic [7:0] a);
    hb(1, 1);
    hb(1, 0);
    put(8'h98);
    put(a);
    hb(0, 1);
    hb(1, 1);
    hb(1, 0);
    put(8'h99);
    for (int i = 7; i >= 0; i--) begin
      hb(0, 1);
      hb(1, 1);
      rd[i] = sda_w;
    end
    put(8'hff);
    hb(0, 0);
    hb(1, 0);
    hb(1, 1);
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // Cycles to the next pixel tick, bounded so a dead clock ends the run
  // Shifted sync may only move with a tick; data clock must rise between
  task automatic gap(output int n);
    logic s0;
    n = 0;
    dck_hi = 0;
    s0 = ls_out;
    do begin
      @(negedge sys_clk);
      n++;
      if (data_clk_out === 1'b1) dck_hi = 1;
      if (pixel_tick !== 1'b1) `CHK(ls_out, s0)
    end while (pixel_tick !== 1'b1 && n < 999);
    if (n >= 999) begin
      mismatches++;
      results();
    end
  endtask
  // Main sequence: registers, decoders, power states, freeze
  initial begin
    repeat (5) @(negedge sys_clk);
    rst_n = 1;
    repeat (3) @(negedge sys_clk);
    rr(PCPC_PWR_ADDR);
    `CHK(rd, PCPC_PWR_RST)
    `CHK(power_state, 2'(pwr(1, 0)))
    div = PCPC_DIV_MIN + $unsigned($random(seed)) % 3875;
    wr(PCPC_DIV_HI_ADDR, div[11:4]);
    wr(PCPC_DIV_LO_ADDR, {div[3:0], 4'h0});
    rr(PCPC_DIV_HI_ADDR);
    `CHK(rd, 8'(div >> 4))
    rr(PCPC_DIV_LO_ADDR);
    `CHK(rd[7:4], 4'(div))
    for (int c = 0; c < 32; c++) begin
      wr(PCPC_LOOP_ADDR, 8'(c << 3));
      `CHK(band_sel, 3'(c < 8 ? 1 : c < 16 ? 2 : 4))
      `CHK(pump_ua, 11'(pump_tab[c % 8]))
    end
    wr(PCPC_LOOP_ADDR, 8'hb0);
    wr(PCPC_SYNC_ADDR, 8'hff);
    rr(PCPC_SYNC_ADDR);
    `CHK(rd & 8'h92, 8'h00)
    rr(8'h30);
    `CHK(rd, 8'h00)
    for (int s = 2; s >= 0; s--) begin
      src_en = 3'(1 << s);
      repeat (120) @(negedge sys_clk);
      rr(PCPC_SYNC_ADDR);
      `CHK(rd & 8'h92, 8'(8'h80 >> (3 * s)))
      `CHK(power_state, 2'(pwr(1, 8'h80 >> (3 * s))))
      `CHK(core_power_en, 1'b1)
    end
    `CHK(data_valid, 1'b1)
    wr(PCPC_PHASE_ADDR, 8'hf8);
    frz_on = 1;
    repeat (20) @(negedge sys_clk);
    gap(t0);
    gap(t0);
    gap(t1);
    `CHK(t1, t0)
    `CHK({dck_hi, data_clk_out}, 2'b10)
    frz_on = 0;
    wr(PCPC_PWR_ADDR, 8'h00);
    `CHK(power_state, 2'(pwr(0, 8'h80)))
    `CHK({core_power_en, keepalive_en, data_valid}, 3'b010)
    src_en = 0;
    wr(PCPC_PWR_ADDR, PCPC_PWR_RST);
    repeat (120) @(negedge sys_clk);
    `CHK(power_state, 2'(pwr(1, 0)))
    results();
  end
endmodule
`default_nettype wire
